// file: verilog/dsb_boot_selector.sv
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dsb_params.svh"
module dsb_boot_selector
	import dsb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        boot_select_pin,
	input  wire logic        boot_option_bit,
	input  wire logic        first_port_receive,
	input  wire logic        second_port_receive,
	output logic             first_port_transmit,
	output logic             second_port_transmit,
	output logic             debug_enable,
	output logic [4:0]       internal_rc_trim,
	output logic [2:0]       wdg_prescale,
	output logic             wdg_refresh,
	output logic [7:0]       sys_clk_mhz,
	output logic [1:0]       flash_wait_states,
	// axi4-lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	dsb_state_t  state_reg;
	dsb_port_t   port_reg;
	logic        strap_reg;
	logic        strap_taken_reg;
	logic        strap_wait_reg;
	logic        boot_mode_reg;
	logic [15:0] baud_reg;
	logic [31:0] addr_reg;
	logic [1:0]  prot_reg;
	logic        tx_busy_reg;
	logic [10:0] tx_shift_reg;
	logic [15:0] tx_cnt_reg;
	logic [3:0]  tx_bits_reg;
	logic [15:0] wdg_cnt_reg;
	logic        wdg_pulse_reg;
	logic        boot_pin_m_reg;
	logic        boot_pin_s_reg;
	logic        opt_m_reg;
	logic        opt_s_reg;
	logic        addr_valid;
	logic [3:0]  wp_sector;
	logic [1:0]  wp_page;
	logic        line1;
	logic        line2;
	logic        done1;
	logic        done2;
	logic [15:0] ticks1;
	logic [15:0] ticks2;
	logic        arm1;
	logic        arm2;
	logic        aw_full_reg;
	logic        w_full_reg;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic        tx_start;
	logic [7:0]  tx_byte_reg;
	logic        tx_req_reg;

	// strap pins come from outside, pass two flops before use
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			boot_pin_m_reg <= 1'b0;
			boot_pin_s_reg <= 1'b0;
			opt_m_reg      <= 1'b0;
			opt_s_reg      <= 1'b0;
		end
		else
		begin
			boot_pin_m_reg <= boot_select_pin;
			boot_pin_s_reg <= boot_pin_m_reg;
			opt_m_reg      <= boot_option_bit;
			opt_s_reg      <= opt_m_reg;
		end

	// strap caught on the third edge after release: the pin flops hold
	// their reset zero until the second edge, so an earlier look sees no pin
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			strap_wait_reg  <= 1'b0;
			strap_reg       <= 1'b0;
			strap_taken_reg <= 1'b0;
		end
		else if (!strap_taken_reg)
		begin
			strap_wait_reg  <= 1'b1;
			strap_reg       <= strap_wait_reg;
			strap_taken_reg <= strap_reg;
		end

	// boot entry needs both straps; debug stays off once entered
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			boot_mode_reg <= 1'b0;
		else if (strap_reg && !strap_taken_reg)
			boot_mode_reg <= boot_pin_s_reg && opt_s_reg;

	assign debug_enable = !boot_mode_reg;

	// fixed boot-mode clock setup and trim reset, reported as levels
	assign sys_clk_mhz       = boot_mode_reg ? 8'(`DSB_SYS_MHZ) : 8'h00;
	assign flash_wait_states = boot_mode_reg ? 2'(`DSB_FLASH_WS) : 2'h0;
	assign internal_rc_trim  = `DSB_TRIM_DEFAULT;
	assign wdg_prescale      = boot_mode_reg ? `DSB_WDG_PRESC_MAX : 3'h0;
	assign wdg_refresh       = wdg_pulse_reg;

	// periodic watchdog kick so a hardware-enabled dog never fires
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			wdg_cnt_reg   <= 16'h0000;
			wdg_pulse_reg <= 1'b0;
		end
		else
		begin
			wdg_pulse_reg <= 1'b0;
			if (boot_mode_reg)
			begin
				if (wdg_cnt_reg == `DSB_WDG_REFRESH)
				begin
					wdg_cnt_reg   <= 16'h0000;
					wdg_pulse_reg <= 1'b1;
				end
				else
					wdg_cnt_reg <= wdg_cnt_reg + 16'h0001;
			end
		end

	// both watchers armed while polling; the loser is disarmed on entering DSB_ST_MEASURE, when the port is chosen
	assign arm1 = (state_reg == DSB_ST_POLL) || (port_reg == DSB_PORT_FIRST);
	assign arm2 = (state_reg == DSB_ST_POLL) || (port_reg == DSB_PORT_SECOND);

	dsb_sync_watch u_watch1 (
		.clk       (clk),
		.rstn      (rstn),
		.rx_pin    (first_port_receive),
		.arm       (arm1),
		.line      (line1),
		.sync_done (done1),
		.bit_ticks (ticks1)
	);

	dsb_sync_watch u_watch2 (
		.clk       (clk),
		.rstn      (rstn),
		.rx_pin    (second_port_receive),
		.arm       (arm2),
		.line      (line2),
		.sync_done (done2),
		.bit_ticks (ticks2)
	);

	// selection: first complete sync byte wins, first port on a tie
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			state_reg <= DSB_ST_IDLE;
			port_reg  <= DSB_PORT_NONE;
			baud_reg  <= 16'h0000;
		end
		else
			case (state_reg)
				DSB_ST_IDLE:
					if (strap_taken_reg)
						state_reg <= boot_mode_reg ? DSB_ST_POLL : DSB_ST_OFF;
				DSB_ST_POLL:
					if (done1)
					begin
						port_reg  <= DSB_PORT_FIRST;
						baud_reg  <= ticks1;
						state_reg <= DSB_ST_MEASURE;
					end
					else if (done2)
					begin
						port_reg  <= DSB_PORT_SECOND;
						baud_reg  <= ticks2;
						state_reg <= DSB_ST_MEASURE;
					end
				DSB_ST_MEASURE:
					state_reg <= DSB_ST_LOCKED;
				DSB_ST_LOCKED:
					state_reg <= DSB_ST_LOCKED;
				DSB_ST_OFF:
					state_reg <= DSB_ST_OFF;
				default:
					state_reg <= DSB_ST_IDLE;
			endcase

	// address window check for read, write and jump targets
	always_comb
	begin
		addr_valid = 1'b0;
		if (addr_reg >= `DSB_RAM_LO && addr_reg < `DSB_RAM_HI)
			addr_valid = 1'b1;
		if (addr_reg >= `DSB_FLASH_LO && addr_reg < `DSB_FLASH_HI)
			addr_valid = 1'b1;
		if (addr_reg >= `DSB_OPT_LO && addr_reg <= `DSB_OPT_HI)
			addr_valid = 1'b1;
		if (addr_reg >= `DSB_SYS_LO && addr_reg < `DSB_SYS_LO + `DSB_SYS_SIZE)
			addr_valid = 1'b1;
	end

	// write-protect granule of the target; only meaningful for flash targets
	assign wp_sector = 4'((addr_reg - `DSB_FLASH_LO) / `DSB_SECTOR_BYTES);
	assign wp_page   = 2'((addr_reg % `DSB_SECTOR_BYTES) / `DSB_PAGE_BYTES);

	// transmitter: 8e1 frame at measured rate, first byte is the ack unless a TXDATA or CHECK write completes in the DSB_ST_MEASURE cycle
	assign tx_start = tx_req_reg && !tx_busy_reg && (state_reg == DSB_ST_LOCKED);
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			tx_busy_reg  <= 1'b0;
			tx_shift_reg <= 11'h7FF;
			tx_cnt_reg   <= 16'h0000;
			tx_bits_reg  <= 4'h0;
		end
		else if (tx_start)
		begin
			tx_busy_reg  <= 1'b1;
			tx_shift_reg <= {1'b1, ^tx_byte_reg, tx_byte_reg, 1'b0};
			tx_cnt_reg   <= 16'h0000;
			tx_bits_reg  <= 4'h0;
		end
		else if (tx_busy_reg)
		begin
			if (tx_cnt_reg + 16'h0001 >= baud_reg)
			begin
				tx_cnt_reg   <= 16'h0000;
				tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
				tx_bits_reg  <= tx_bits_reg + 4'h1;
				if (tx_bits_reg == 4'hA)
					tx_busy_reg <= 1'b0;
			end
			else
				tx_cnt_reg <= tx_cnt_reg + 16'h0001;
		end

	// only the locked port drives; the other idles high
	assign first_port_transmit  = (port_reg == DSB_PORT_FIRST) ? tx_shift_reg[0] : 1'b1;
	assign second_port_transmit = (port_reg == DSB_PORT_SECOND) ? tx_shift_reg[0] : 1'b1;

	// axi write: address and data taken in either order, then response
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg  <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			addr_reg    <= 32'h0000_0000;
			prot_reg    <= `DSB_PROT_LVL0;
			tx_req_reg  <= 1'b0;
			tx_byte_reg <= 8'h00;
		end
		else
		begin
			if (state_reg == DSB_ST_MEASURE)
			begin
				tx_req_reg  <= 1'b1;
				tx_byte_reg <= `DSB_ACK_BYTE;
			end
			else if (tx_start)
				tx_req_reg <= 1'b0;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
			end
			if (aw_full_reg && w_full_reg)
			begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				case (aw_addr_reg)
					`DSB_REG_ADDR:
						addr_reg <= w_data_reg;
					`DSB_REG_PROT:
						prot_reg <= w_data_reg[0] ? `DSB_PROT_LVL1 : `DSB_PROT_LVL0;
					`DSB_REG_TXDATA:
						if (!tx_req_reg)
						begin
							tx_req_reg  <= 1'b1;
							tx_byte_reg <= w_data_reg[7:0];
						end
					`DSB_REG_CHECK:
						if (!tx_req_reg)
						begin
							tx_req_reg  <= 1'b1;
							tx_byte_reg <= addr_valid ? `DSB_ACK_BYTE : `DSB_NACK_BYTE;
						end
					`DSB_REG_CTRL:
						s_axi_bresp <= 2'b00;
					default:
						s_axi_bresp <= 2'b10;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end

	// axi read: data one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'b00;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			case (s_axi_araddr)
				`DSB_REG_CTRL:
					s_axi_rdata <= {31'h0000_0000, boot_mode_reg};
				`DSB_REG_STATUS:
					s_axi_rdata <= {24'h00_0000, tx_req_reg, tx_busy_reg, line2, line1,
						1'b0, state_reg};
				`DSB_REG_BAUD:
					s_axi_rdata <= {16'h0000, baud_reg};
				`DSB_REG_ADDR:
					s_axi_rdata <= addr_reg;
				`DSB_REG_CHECK:
					s_axi_rdata <= {20'h0_0000, wp_sector, 2'h0, wp_page, 3'h0, addr_valid};
				`DSB_REG_PROT:
					s_axi_rdata <= {30'h0000_0000, prot_reg};
				`DSB_REG_PID:
					s_axi_rdata <= {20'h0_0000, `DSB_PRODUCT_ID};
				`DSB_REG_TXDATA:
					s_axi_rdata <= {24'h00_0000, tx_byte_reg};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'b10;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
endmodule : dsb_boot_selector
`default_nettype wire

// file: common/dsb_params.svh
// Contract
// - boot mode entered only with boot select pin high at reset and option bit 1
// - during selection both serial ports are polled continuously
// - host sends 0x7F first; device measures baud then waits for commands
// - once a port is chosen the other port is disabled for the session
// - frames are eight data bits, even parity, one stop bit on both sides; the bench host sends no stop bit
// - bit period measured with the tick timer, no fixed preset rate
// - boot mode runs at 24 MHz from PLL with one flash wait state
// - watchdog prescaler set to maximum and refreshed periodically during boot
// - first 2 Kbytes of RAM from 0x20000000 reserved for boot working storage
// - boot program lives in 3 Kbyte system memory from 0x1FFFEC00
// - debug access unavailable after boot entry until next system reset
// - read-protect sets protection level 1, read-unprotect sets level 0
// - RAM 0x20000800..0x20002000 and flash 0x08000000..0x08010000 are valid
// - option bytes up to 0x1FFFF80B and system memory from 0x1FFFEC00 valid
// - device reports its product identifier on request
// - write-protect works on 4 Kbyte sectors of four 1 Kbyte pages
// - internal RC trim forced to 0 at boot start
// - unsupported request or address answered with negative acknowledge 0x1F; an unknown AXI register gets SLVERR 2'b10, not 0x1F
`ifndef DSB_PARAMS_SVH
`define DSB_PARAMS_SVH
`define DSB_SYNC_BYTE      8'h7F
`define DSB_NACK_BYTE      8'h1F
`define DSB_ACK_BYTE       8'h79
`define DSB_CLK_HZ         40000000
`define DSB_SYS_MHZ        24
`define DSB_FLASH_WS       1
`define DSB_PROT_LVL1      2'h1
`define DSB_PROT_LVL0      2'h0
`define DSB_TRIM_DEFAULT   5'h00
`define DSB_WDG_PRESC_MAX  3'h7
`define DSB_WDG_REFRESH    16'h0FA0
`define DSB_RAM_BOOT_BASE  32'h2000_0000
`define DSB_RAM_BOOT_SIZE  32'h0000_0800
`define DSB_RAM_LO         32'h2000_0800
`define DSB_RAM_HI         32'h2000_2000
`define DSB_FLASH_LO       32'h0800_0000
`define DSB_FLASH_HI       32'h0801_0000
`define DSB_SYS_LO         32'h1FFF_EC00
`define DSB_SYS_SIZE       32'h0000_0C00
`define DSB_OPT_LO         32'h1FFF_F800
`define DSB_OPT_HI         32'h1FFF_F80B
`define DSB_SECTOR_BYTES   32'h0000_1000
`define DSB_PAGE_BYTES     32'h0000_0400
`define DSB_PRODUCT_ID     12'h0A5
`define DSB_REG_CTRL       12'h000
`define DSB_REG_STATUS     12'h004
`define DSB_REG_BAUD       12'h008
`define DSB_REG_ADDR       12'h00C
`define DSB_REG_CHECK      12'h010
`define DSB_REG_PROT       12'h014
`define DSB_REG_PID        12'h018
`define DSB_REG_TXDATA     12'h01C
`endif

// file: common/dsb_pkg.sv
package dsb_pkg;
	typedef enum logic [2:0] {
		DSB_ST_IDLE,
		DSB_ST_POLL,
		DSB_ST_MEASURE,
		DSB_ST_LOCKED,
		DSB_ST_OFF
	} dsb_state_t;
	typedef enum logic [1:0] {
		DSB_PORT_NONE,
		DSB_PORT_FIRST,
		DSB_PORT_SECOND
	} dsb_port_t;
endpackage : dsb_pkg

// file: verilog/dsb_sync_watch.sv
`timescale 1ns/10ps
`default_nettype none
// per-port receive watcher: synchronises the line and times the sync byte
module dsb_sync_watch
	import dsb_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        rx_pin,
	input  wire logic        arm,
	output logic             line,
	output logic             sync_done,
	output logic [15:0]      bit_ticks
);
	logic        meta_reg;
	logic        line_reg;
	logic        prev_reg;
	logic        busy_reg;
	logic [19:0] cnt_reg;
	logic        done_reg;
	logic [15:0] ticks_reg;

	// two-flop synchroniser, first flop read only by the second
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			meta_reg <= 1'b1;
			line_reg <= 1'b1;
			prev_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= rx_pin;
			line_reg <= meta_reg;
			prev_reg <= line_reg;
		end

	// 0x7F is start bit low, then seven ones high, then one low bit: the first
	// low run lasts one bit time (start) and the line rises; next fall ends
	// eight bit times after the start, so the span gives the bit period
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			busy_reg  <= 1'b0;
			cnt_reg   <= 20'h0_0000;
			done_reg  <= 1'b0;
			ticks_reg <= 16'h0000;
		end
		else
		begin
			done_reg <= 1'b0;
			if (!arm)
			begin
				busy_reg <= 1'b0;
				cnt_reg  <= 20'h0_0000;
			end
			else if (!busy_reg && prev_reg && !line_reg)
			begin
				busy_reg <= 1'b1;
				cnt_reg  <= 20'h0_0001;
			end
			else if (busy_reg && prev_reg && !line_reg)
			begin
				busy_reg  <= 1'b0;
				done_reg  <= 1'b1;
				ticks_reg <= cnt_reg[18:3];
			end
			else if (busy_reg)
				cnt_reg <= cnt_reg + 20'h0_0001;
		end

	assign line      = line_reg;
	assign sync_done = done_reg;
	assign bit_ticks = ticks_reg;
endmodule : dsb_sync_watch
`default_nettype wire

// file: test/dsb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host end of one serial port: sends frames, decodes device replies
module dsb_host_model #(
	parameter int BIT = 16
) (
	input  wire logic       clk,
	input  wire logic       line_in,
	output logic            line_out,
	output logic [8:0]      got,
	output logic [7:0]      n_got
);
	// idle high, so an unused port never floats
	initial
	begin
		line_out = 1'b1;
		n_got = 8'h00;
	end
	// start, data lsb first, even parity; no stop bit, line left at the parity level
	task automatic send(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, ^b, b, 1'b0};
		for (int k = 0; k < 10; k++)
		begin
			line_out <= fr[k];
			repeat (BIT) @(posedge clk);
		end
	endtask : send
	// mid-bit sampling; parity kept in bit 8 so the bench can judge it
	always
	begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge clk);
		for (int k = 0; k < 9; k++)
		begin
			repeat (BIT) @(posedge clk);
			got[k] = line_in;
		end
		n_got = n_got + 8'h01;
	end
endmodule : dsb_host_model
`default_nettype wire

// file: test/dsb_boot_selector_properties.sv
`timescale 1ns/10ps
`default_nettype none
// output checks of the boot selector
module dsb_boot_selector_chk (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        debug_enable,
	input wire logic        wdg_refresh,
	input wire logic [2:0]  wdg_prescale,
	input wire logic [4:0]  internal_rc_trim,
	input wire logic [7:0]  sys_clk_mhz,
	input wire logic [1:0]  flash_wait_states,
	input wire logic        first_port_transmit,
	input wire logic        second_port_transmit,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	logic [12:0] gap_reg;
	logic        seen_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// cycles since last refresh; first pulse has no reference
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			gap_reg <= 13'h0000;
		else if (wdg_refresh)
			gap_reg <= 13'h0000;
		else
			gap_reg <= gap_reg + 13'h0001;
	end
	// remembers that one refresh was seen this session
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			seen_reg <= 1'b0;
		else if (wdg_refresh)
			seen_reg <= 1'b1;
	end
	boot_clock_a: assert property (!debug_enable |-> sys_clk_mhz == 8'h18 && flash_wait_states == 2'h1)
		else $error("boot clock setup wrong");
	dog_presc_a: assert property (!debug_enable |-> wdg_prescale == 3'h7)
		else $error("watchdog prescaler wrong");
	normal_mode_a: assert property (debug_enable |-> sys_clk_mhz == 8'h00 && !wdg_refresh)
		else $error("boot setup outside boot mode");
	trim_zero_a: assert property (internal_rc_trim == 5'h00)
		else $error("trim not default");
	debug_lock_a: assert property (!debug_enable |=> !debug_enable)
		else $error("debug came back in session");
	refresh_gap_a: assert property (wdg_refresh && seen_reg |-> gap_reg == 13'h0FA0)
		else $error("refresh period wrong");
	refresh_late_a: assert property (seen_reg |-> gap_reg <= 13'h0FA0)
		else $error("refresh overdue");
	one_port_a: assert property (first_port_transmit || second_port_transmit)
		else $error("both ports transmit");
	tx_idle_a: assert property (debug_enable |-> first_port_transmit && second_port_transmit)
		else $error("transmit outside boot mode");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write answer late");
endmodule : dsb_boot_selector_chk
bind dsb_boot_selector dsb_boot_selector_chk dsb_boot_selector_chk_i (.clk, .rstn, .debug_enable,
	.wdg_refresh, .wdg_prescale, .internal_rc_trim, .sys_clk_mhz, .flash_wait_states,
	.first_port_transmit, .second_port_transmit, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata);
`default_nettype wire

// file: test/dsb_boot_selector_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module dsb_boot_selector_tb_top
	import dsb_pkg::*;
();
	logic        clk = 1'b0, rstn = 1'b0, boot_select_pin = 1'b0, boot_option_bit = 1'b0;
	logic        first_port_receive, second_port_receive, first_port_transmit;
	logic        second_port_transmit, debug_enable, wdg_refresh;
	logic [4:0]  internal_rc_trim;
	logic [2:0]  wdg_prescale;
	logic [7:0]  sys_clk_mhz, h1_n, h2_n;
	logic [1:0]  flash_wait_states, s_axi_bresp, s_axi_rresp, r;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [8:0]  h2_got;
	int          n_mismatch = 0, n_checks = 0, cyc = 0;
	// address, with bit 32 set where the address is a valid target
	localparam logic [32:0] win_tab [11] = '{{1'b1, 32'h2000_0800}, {1'b0, 32'h2000_07FC},
		{1'b1, 32'h2000_1FFC}, {1'b0, 32'h2000_2000}, {1'b1, 32'h0800_0000},
		{1'b1, 32'h0800_FFFC}, {1'b0, 32'h0801_0000}, {1'b1, 32'h1FFF_EC00},
		{1'b0, 32'h1FFF_EBFC}, {1'b1, 32'h1FFF_F80B}, {1'b0, 32'h1FFF_F80C}};

	always #12.5 clk = ~clk;

	dsb_host_model first_host_i (.clk, .line_in(first_port_transmit),
		.line_out(first_port_receive), .got(), .n_got(h1_n));
	dsb_host_model second_host_i (.clk, .line_in(second_port_transmit),
		.line_out(second_port_receive), .got(h2_got), .n_got(h2_n));
	dsb_boot_selector dsb_boot_selector_i (.clk, .rstn, .boot_select_pin, .boot_option_bit,
		.first_port_receive, .second_port_receive, .first_port_transmit, .second_port_transmit,
		.debug_enable, .internal_rc_trim, .wdg_prescale, .wdg_refresh, .sys_clk_mhz,
		.flash_wait_states, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : do_reset
	// readies sampled mid-cycle so the handshake edge is known without races
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic ta, tw, tb;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge clk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
	endtask : wr
	// rready raised late so read data must stand a cycle
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		logic ta, tv;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(negedge clk);
			ta = s_axi_arready;
			tv = s_axi_rvalid;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tv);
		s_axi_rready <= 1'b1;
		@(negedge clk);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		@(posedge clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	// waits for one reply byte, then two bit times of slack
	task automatic wait_byte(input int c0, input logic [8:0] exp);
		int i;
		i = 0;
		while (h2_n == c0 && i < 800)
		begin
			@(posedge clk);
			i++;
		end
		chk(32'(h2_n) - 32'(c0), 32'h1);
		chk(32'(h2_got), 32'(exp));
		repeat (32) @(posedge clk);
	endtask : wait_byte
	task automatic t_straps();
		for (int i = 0; i < 4; i++)
		begin
			boot_select_pin <= i[1];
			boot_option_bit <= i[0];
			do_reset();
			rd(12'h000, d, r);
			chk(32'(d[0]), 32'(i == 3));
			chk(32'(debug_enable), 32'(i != 3));
		end
		rd(12'h018, d, r);
		chk(d, 32'h0000_00A5);
		rd(12'h004, d, r);
		chk(32'(d[2:0]), 32'(DSB_ST_POLL));
	endtask : t_straps
	task automatic t_sync();
		int c0;
		c0 = h2_n;
		second_host_i.send(8'h7F);
		wait_byte(c0, {^8'h79, 8'h79});
		rd(12'h004, d, r);
		chk(32'(d[2:0]), 32'(DSB_ST_LOCKED));
		rd(12'h008, d, r);
		chk(d, 32'h0000_0010);
		first_host_i.send(8'h7F);
		repeat (200) @(posedge clk);
		rd(12'h004, d, r);
		chk(32'(d[2:0]), 32'(DSB_ST_LOCKED));
		chk(32'(h1_n), 32'h0);
	endtask : t_sync
	task automatic t_window();
		for (int i = 0; i < 11; i++)
		begin
			wr(12'h00C, win_tab[i][31:0], r);
			rd(12'h010, d, r);
			chk(32'(d[0]), 32'(win_tab[i][32]));
			if (i == 5) chk(32'(d[11:4]), 32'h0000_00F3);
		end
	endtask : t_window
	task automatic t_nack();
		int c0;
		wr(12'h00C, 32'h2000_2000, r);
		c0 = h2_n;
		wr(12'h010, 32'h0, r);
		wait_byte(c0, {^8'h1F, 8'h1F});
		wr(12'h00C, 32'h0800_0000, r);
		c0 = h2_n;
		wr(12'h010, 32'h0, r);
		wait_byte(c0, {^8'h79, 8'h79});
	endtask : t_nack
	task automatic t_regs();
		wr(12'h014, 32'h1, r);
		rd(12'h014, d, r);
		chk(d, 32'h1);
		wr(12'h014, 32'h0, r);
		rd(12'h014, d, r);
		chk(d, 32'h0);
		rd(12'h100, d, r);
		chk({30'h0, r}, 32'h2);
		chk(d, 32'h0);
		wr(12'h100, 32'h0, r);
		chk({30'h0, r}, 32'h2);
		repeat (9000) @(posedge clk);
		chk(32'(wdg_prescale), 32'h7);
	endtask : t_regs
	// cycle ceiling against a hang
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_mismatch++;
			summarize();
		end
	end
	initial
	begin
		t_straps();
		t_sync();
		t_window();
		t_nack();
		t_regs();
		summarize();
	end
endmodule : dsb_boot_selector_tb_top
`default_nettype wire
